// [carrier_output_cfg.svh]
/*
 * Constants of the carrier output control stage: register address,
 * bit positions and reset value.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef CARRIER_OUTPUT_CFG_SVH
`define CARRIER_OUTPUT_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define COC_ADDR        16'hff6d
`define COC_RESET       8'h00
`define COC_BIT_STATUS  3'h0
`define COC_BIT_NEXT    3'h1
`define COC_BIT_ENABLE  3'h2
// Bit of the write data that carries a single-bit write
`define COC_BIT_WVAL    3'h0

`endif

// [carrier_output_pkg.sv]
/*
 * Types shared by the carrier output control stage.
 * Assumes carrier_output_cfg.svh is on the include path.
 */
`include "carrier_output_cfg.svh"
package carrier_output_pkg;
  // Width of the special function register data bus
  typedef logic [7:0]  sfr_data_t;
  // Width of the special function register address bus
  typedef logic [15:0] sfr_addr_t;
  // Write access kinds seen on the register port
  typedef enum logic [1:0]
  {
    access_none,
    access_byte,
    access_bit
  } access_kind_t;
endpackage : carrier_output_pkg

// [carrier_output_control.sv]
/*
 * Carrier and remote-control output stage of an 8-bit timer.
 * A control register picks low, high or carrier pulses on the output;
 * the on/off choice takes effect on the rising edge of the second timer's
 * interrupt. Assumes that the interrupt, the carrier timer output and
 * the port bits come from logic on clk_in, and that software obeys
 * the run-time write restrictions.
 */
`include "carrier_output_cfg.svh"
module carrier_output_control
  import carrier_output_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  input  wire carrier_output_pkg::sfr_addr_t addr_in,
  input  wire carrier_output_pkg::sfr_data_t wdata_in,
  input  wire logic                          wr_byte_in,
  input  wire logic                          wr_bit_in,
  input  wire logic [2:0]                    bit_sel_in,
  output      carrier_output_pkg::sfr_data_t rdata_out,
  input  wire logic                          second_timer_interrupt_in,
  input  wire logic                          carrier_timer_output_in,
  input  wire logic                          carrier_timer_run_enable_in,
  input  wire logic                          pin_direction_bit_in,
  input  wire logic                          pin_latch_bit_in,
  output logic                               remote_out,
  output logic                               pin_level_out,
  output logic                               pin_oe_n_out
);
  import carrier_output_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic carrier_enable_bit;     // Selects carrier pulses over a level
  logic next_level_bit;         // Level applied at next interrupt edge
  logic carrier_status_flag;    // Current output state, read-only
  logic interrupt_prev;         // Previous interrupt level for edges
  logic interrupt_rise;         // One-cycle rising edge of interrupt
  logic hit;                    // Register address decoded
  access_kind_t access_kind;    // Kind of write this cycle
  sfr_data_t    next_rdata;     // Read data to be registered
  // Reset image of the register, so the enable and next-level reset values come from one place
  localparam sfr_data_t reset_image = `COC_RESET;

  assign hit = (addr_in == `COC_ADDR);

  // Decode the write strobes; a byte write wins if both arrive
  always_comb
  begin
    if (hit && wr_byte_in)
      access_kind = access_byte;
    else if (hit && wr_bit_in)
      access_kind = access_bit;
    else
      access_kind = access_none;
  end

  // Writable control bits; bit writes touch only the selected bit
  // reset to zero
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      carrier_enable_bit <= reset_image[`COC_BIT_ENABLE];
      next_level_bit     <= reset_image[`COC_BIT_NEXT];
    end
    else
    begin
      case (access_kind)
        access_byte:
        begin
          carrier_enable_bit <= wdata_in[`COC_BIT_ENABLE];
          next_level_bit     <= wdata_in[`COC_BIT_NEXT];
        end
        access_bit:
        begin
          if (bit_sel_in == `COC_BIT_ENABLE)
            carrier_enable_bit <= wdata_in[`COC_BIT_WVAL];
          if (bit_sel_in == `COC_BIT_NEXT)
            next_level_bit <= wdata_in[`COC_BIT_WVAL];
        end
        default:
        begin
          carrier_enable_bit <= carrier_enable_bit;
        end
      endcase
    end
  end

  // Edge detector on the interrupt, which is on this same clock
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      interrupt_prev <= 1'b0;
    else
      interrupt_prev <= second_timer_interrupt_in;
  end

  assign interrupt_rise = second_timer_interrupt_in && !interrupt_prev;

  // Status flag follows next-level only at interrupt edges, so a
  // next-level write mid-period never glitches the output.
  // software writes ignored
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      carrier_status_flag <= 1'b0;
    else if (interrupt_rise)
      carrier_status_flag <= next_level_bit;
  end

  // Read data built from the live bits; bits above the enable read zero
  // status visible
  always_comb
  begin
    next_rdata = 8'h00;
    if (hit)
    begin
      next_rdata[`COC_BIT_ENABLE] = carrier_enable_bit;
      next_rdata[`COC_BIT_NEXT]   = next_level_bit;
      next_rdata[`COC_BIT_STATUS] = carrier_status_flag;
    end
  end

  // Read data leaves through a flip-flop, so it trails the address by
  // one clock; software must allow that cycle before taking the value
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_out <= 8'h00;
    else
      rdata_out <= next_rdata;
  end

  // Output register; carrier pulses pass through the enable gate
  // low when disabled
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      remote_out <= 1'b0;
    else if (!carrier_status_flag)
      remote_out <= 1'b0;
    else if (carrier_enable_bit)
      remote_out <= carrier_timer_output_in;
    else
      remote_out <= 1'b1;
  end

  // Shared pin: output mode drives remote output ANDed with inverted latch,
  // input mode releases the pin (enable high means not driving)
  // port bits gate
  always_comb
  begin
    pin_oe_n_out  = pin_direction_bit_in;
    pin_level_out = remote_out && !pin_direction_bit_in
                    && !pin_latch_bit_in;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  status_takes_next_a: assert property (
    interrupt_rise |=> carrier_status_flag == $past(next_level_bit))
    else $error("status flag did not take next-level at edge");

  status_holds_a: assert property (
    !interrupt_rise |=> $stable(carrier_status_flag))
    else $error("status flag changed without interrupt edge");

  output_low_off_a: assert property (
    !carrier_status_flag |=> !remote_out)
    else $error("output not low while disabled");

  high_level_a: assert property (
    carrier_status_flag && !carrier_enable_bit |=> remote_out)
    else $error("high level mode output not high");

  carrier_pass_a: assert property (
    carrier_status_flag && carrier_enable_bit
    |=> remote_out == $past(carrier_timer_output_in))
    else $error("carrier pulse not passed to output");

  byte_write_a: assert property (
    access_kind == access_byte
    |=> carrier_enable_bit == $past(wdata_in[`COC_BIT_ENABLE])
        && next_level_bit == $past(wdata_in[`COC_BIT_NEXT]))
    else $error("byte write not stored");

  bit_write_a: assert property (
    access_kind == access_bit && bit_sel_in == `COC_BIT_NEXT
    |=> next_level_bit == $past(wdata_in[`COC_BIT_WVAL])
        && $stable(carrier_enable_bit))
    else $error("bit write disturbed another bit");

  read_status_a: assert property (
    hit |=> rdata_out[`COC_BIT_STATUS] == $past(carrier_status_flag))
    else $error("status flag not visible on read");

  pin_release_a: assert property (
    pin_direction_bit_in |-> pin_oe_n_out && !pin_level_out)
    else $error("pin driven in input mode");

  cover_carrier_c: cover property (
    interrupt_rise && next_level_bit && carrier_enable_bit
    && carrier_timer_run_enable_in);
  cover_high_c: cover property (
    interrupt_rise && next_level_bit && !carrier_enable_bit);
  cover_stop_c: cover property (
    carrier_status_flag && interrupt_rise && !next_level_bit);

endmodule : carrier_output_control

// [carrier_far_model.sv]
/*
 * Far-side model: second timer interrupt and carrier timer pulses.
 * Assumes one clock shared with the output stage under test.
 */
module carrier_far_model
(
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic run_in,
  input  wire logic fire_in,
  output logic      tick_int_out,
  output logic      carrier_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // clean restart, carrier clock fastest
  // Toggling every cycle keeps it far above the interrupt rate
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      carrier_out <= 1'b0;
    else
      carrier_out <= run_in ? ~carrier_out : 1'b0;
  // Interrupt level follows the request one cycle late
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      tick_int_out <= 1'b0;
    else
      tick_int_out <= fire_in;
endmodule : carrier_far_model

// [carrier_remote_output_control_bench.sv]
/*
 * Bench for the carrier output stage: register, mode and pin checks.
 * Assumes the far-side model shares clk_in with the stage.
 */
module carrier_remote_output_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import carrier_output_pkg::*;
  logic       clk_in = 0, rstn_in = 0, wr_byte = 0, wr_bit = 0;
  logic       dir = 0, latch = 0, fire = 0, run = 0;
  logic [2:0] bsel = 3'h0;
  sfr_addr_t  addr = 16'h0000;
  sfr_data_t  wdata = 8'h00, rdata;
  logic       tint, carr, remote, pin, oe_n;
  int         bad_count = 0, tests_run = 0;
  carrier_output_control dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr), .wdata_in(wdata), .wr_byte_in(wr_byte),
    .wr_bit_in(wr_bit), .bit_sel_in(bsel), .rdata_out(rdata),
    .second_timer_interrupt_in(tint), .carrier_timer_output_in(carr),
    .carrier_timer_run_enable_in(run), .pin_direction_bit_in(dir),
    .pin_latch_bit_in(latch), .remote_out(remote),
    .pin_level_out(pin), .pin_oe_n_out(oe_n));
  carrier_far_model far_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .run_in(run), .fire_in(fire), .tick_int_out(tint),
    .carrier_out(carr));
  initial forever #50 clk_in = ~clk_in;
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : check
  task automatic wr(logic bm, sfr_addr_t a, sfr_data_t d, logic [2:0] s);
    @(posedge clk_in);
    addr <= a; wdata <= d; bsel <= s; wr_byte <= ~bm; wr_bit <= bm;
    @(posedge clk_in);
    wr_byte <= 1'b0; wr_bit <= 1'b0;
  endtask : wr
  task automatic rd(sfr_addr_t a, sfr_data_t e, string what);
    @(posedge clk_in);
    addr <= a;
    @(posedge clk_in);
    #1 check(what, rdata, e);
  endtask : rd
  // Timer stopped while the enable bit changes, then one interrupt
  task automatic set_mode(logic [1:0] m);
    @(posedge clk_in) run <= 1'b0;
    wr(1'b0, 16'hff6d, {5'h00, m, 1'b0}, 3'h0);
    @(posedge clk_in) run <= 1'b1;
    @(posedge clk_in) fire <= 1'b1;
    @(posedge clk_in) fire <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask : set_mode
  task automatic t_reg;
    rd(16'hff6d, 8'h00, "after reset");
    wr(1'b0, 16'hff6d, 8'hff, 3'h0);
    rd(16'hff6d, 8'h06, "byte write");
    wr(1'b1, 16'hff6d, 8'h00, 3'h1);
    rd(16'hff6d, 8'h04, "next clear");
    wr(1'b1, 16'hff6d, 8'h00, 3'h2);
    rd(16'hff6d, 8'h00, "enable clear");
    wr(1'b1, 16'hff6d, 8'h01, 3'h0);
    rd(16'hff6d, 8'h00, "status write");
    wr(1'b0, 16'hff6c, 8'hff, 3'h0);
    rd(16'hff6d, 8'h00, "unmapped");
    $display("test registers done");
  endtask : t_reg
  task automatic t_modes;
    logic r0;
    for (int m = 0; m < 4; m++)
    begin
      set_mode(m[1:0]);
      check("status", {7'h00, rdata[0]}, {7'h00, m[0]});
      r0 = remote;
      if (m == 3)
      begin
        @(posedge clk_in);
        #1 check("carrier", {7'h00, remote}, {7'h00, ~r0});
      end
      else
        check("level", {7'h00, remote}, {7'h00, m == 1});
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_pin;
    set_mode(2'h1);
    check("pin", {6'h00, pin, oe_n}, 8'h02);
    @(posedge clk_in) latch <= 1'b1;
    #1 check("latched pin", {6'h00, pin, oe_n}, 8'h00);
    @(posedge clk_in) dir <= 1'b1;
    #1 check("input pin", {6'h00, pin, oe_n}, 8'h01);
    $display("test pin done");
  endtask : t_pin
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Whole run needs about 80 cycles
  initial
  begin
    repeat (2000) @(posedge clk_in);
    bad_count++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reg();
    t_modes();
    t_pin();
    test_done();
  end
endmodule : carrier_remote_output_control_bench
